/* File: logic/spp_sequencer.v */
// Setpoint program run/hold sequencer with register port and contact inputs
// What this block does
// - Program parameter writes accepted in hold or after end, refused while running.
// - Run key starts the program and lights the run indicator.
// - Hold key enters hold, freezing the working setpoint, hold indicator on.
// - External hold contact closing while running enters hold.
// - Keypad run/hold request outranks the external switch.
// - Reopening the external hold contact resumes running.
// - Report segment 1..12, ramp or soak, and remaining hours and minutes.
// - Keep and report cycles left, range 0 to 99.
// - After last segment: hold if configured, else disable and clear run.
// - After end: keep last setpoint or go manual with failsafe output.
// - Power-up after loss: hold, at program start, pre-program setpoint.
// - Power-up control mode is always manual; the power-up mode bit is read at its reset value 0.
// - Contact for run function closing enters running.
// - Contact for hold function closing enters hold only while running; from hold or end the mode is unchanged.
// - Restart-cycle contact returns to first segment, mode unchanged.
// - Opening run contact, or hold contact after it entered hold, restores the previous state; opening restart contact restores the previous segment.
// - Begin contact returns to first segment in hold; reopening ignored.
// - Begin leaves the remaining cycle count unchanged.
// - Hold indicator flashes while a hold entered by the external hold contact lasts, until the contact opens or the state changes.
// - Zero soak band: soak timing starts once setpoint first reached.
// - Nonzero soak band: soak timer halts while PV outside the band.
`include "spp_map.vh"
`default_nettype none

module spp_sequencer #(
    parameter [39:0] MINUTE_CYCLES = `MINUTE_CYC,
    parameter [19:0] DEB_CYCLES    = `DEB_CYC
) (
    input  wire        core_clk_i,
    input  wire        resetn_i,
    input  wire [3:0]  addr_i,
    input  wire [15:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [15:0] rdata_o,
    input  wire        din_contact_i,
    input  wire        pv_at_sp_i,
    input  wire        pv_in_band_i,
    output reg         running_o,
    output reg         hold_ind_o,
    output reg         sp_frozen_o,
    output reg         sp_restore_o,
    output reg         manual_failsafe_o,
    output reg         manual_mode_o,
    output reg         param_refused_o
);

    localparam [2:0] ST_HOLD = 3'b001;
    localparam [2:0] ST_RUN  = 3'b010;
    localparam [2:0] ST_OFF  = 3'b100;

    reg        rst_m_r;
    reg        rst_n_r;
    reg        din_m_r;
    reg        din_s_r;
    reg        din_stable_r;
    reg [19:0] deb_cnt_r;
    reg [2:0]  state_r;
    reg [2:0]  saved_state_r;
    reg [3:0]  seg_r;
    reg [3:0]  saved_seg_r;
    reg [5:0]  min_r;
    reg [7:0]  hrs_r;
    reg [39:0] tick_cnt_r;
    reg [6:0]  cycles_r;
    reg [6:0]  cycles_cfg_r;
    reg [5:0]  ctrl_r;
    reg [2:0]  din_fn_r;
    reg [11:0] seg_soak_r;
    reg [13:0] seg_time_r;
    reg        soak_armed_r;
    reg        soak_band_nz_r;
    reg [26:0] blink_r;
    reg        ext_hold_r;
    reg        power_up_mode_setting_r;
    reg        rd_pend_r;
    reg [15:0] rd_val_r;
    reg [2:0]  state_nxt;

    wire din_rise;
    wire din_fall;
    wire minute_tick;
    wire is_soak;
    wire seg_done;
    wire param_wr;

    // Segment type lookup, bit per segment
    function seg_is_soak;
        input [11:0] mask;
        input [3:0]  seg;
        begin
            seg_is_soak = mask[seg - `SEG_FIRST];
        end
    endfunction

    // Reset release through two flops
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_m_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_n_r <= rst_m_r;
        end
    end

    // Contact synchroniser and debouncer
    always @(posedge core_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            din_m_r      <= 1'b0;
            din_s_r      <= 1'b0;
            din_stable_r <= 1'b0;
            deb_cnt_r    <= 20'h00000;
        end else begin
            din_m_r <= din_contact_i;
            din_s_r <= din_m_r;
            if (din_s_r == din_stable_r) begin
                deb_cnt_r <= 20'h00000;
            end else if (deb_cnt_r == DEB_CYCLES - 20'h00001) begin
                deb_cnt_r    <= 20'h00000;
                din_stable_r <= din_s_r;
            end else begin
                deb_cnt_r <= deb_cnt_r + 20'h00001;
            end
        end
    end

    assign din_rise = (din_s_r != din_stable_r) && din_s_r &&
                      (deb_cnt_r == DEB_CYCLES - 20'h00001);
    assign din_fall = (din_s_r != din_stable_r) && !din_s_r &&
                      (deb_cnt_r == DEB_CYCLES - 20'h00001);

    assign minute_tick = (tick_cnt_r == MINUTE_CYCLES - 40'h0000000001);
    assign is_soak     = seg_is_soak(seg_soak_r, seg_r);
    assign seg_done    = (hrs_r == 8'h00) && (min_r == 6'h00);
    assign param_wr    = wr_i && (addr_i == `REG_SEG_CFG ||
                         addr_i == `REG_CYCLES ||
                         addr_i == `REG_DIN_CFG || addr_i == `REG_SOAK ||
                         addr_i == `REG_TIME);

    // Run/hold decision
    always @* begin
        state_nxt = state_r;
        if (wr_i && addr_i == `REG_CTRL && wdata_i[`CTRL_RUN_KEY]) begin
            state_nxt = ST_RUN;
        end else if (wr_i && addr_i == `REG_CTRL &&
                     wdata_i[`CTRL_HOLD_KEY]) begin
            state_nxt = ST_HOLD;
        end else if (din_rise) begin
            case (din_fn_r)
                `DIN_RUN_HOLD: begin
                    if (state_r == ST_RUN) begin
                        state_nxt = ST_HOLD;
                    end
                end
                `DIN_BEGIN: state_nxt = ST_HOLD;
                `DIN_FN_RUN: begin
                    state_nxt = ST_RUN;
                end
                default: state_nxt = state_r;
            endcase
        end else if (din_fall) begin
            case (din_fn_r)
                `DIN_RUN_HOLD: begin
                    if (ext_hold_r) begin
                        state_nxt = saved_state_r;
                    end
                end
                `DIN_FN_RUN: begin
                    state_nxt = saved_state_r;
                end
                default: state_nxt = state_r;
            endcase
        end else if (state_r == ST_RUN && seg_done && minute_tick &&
                     seg_r == `SEG_LAST && cycles_r == 7'h00) begin
            state_nxt = ctrl_r[`CTRL_END_HOLD] ? ST_HOLD : ST_OFF;
        end
    end

    // Sequencer state, segment and timers
    always @(posedge core_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r       <= ST_HOLD;
            saved_state_r <= ST_HOLD;
            seg_r         <= `SEG_FIRST;
            saved_seg_r   <= `SEG_FIRST;
            min_r         <= 6'h00;
            hrs_r         <= 8'h00;
            tick_cnt_r    <= 40'h0000000000;
            cycles_r      <= `CYCLES_RST;
            soak_armed_r  <= 1'b0;
            ext_hold_r    <= 1'b0;
            power_up_mode_setting_r      <= 1'b1;
        end else begin
            state_r  <= state_nxt;
            power_up_mode_setting_r <= 1'b0;
            if (din_rise && din_fn_r == `DIN_FN_RUN) begin
                saved_state_r <= state_r;
                ext_hold_r    <= 1'b0;
            end else if (din_rise && din_fn_r == `DIN_RUN_HOLD) begin
                saved_state_r <= state_r;
                ext_hold_r    <= (state_r == ST_RUN);
            end else if (din_fall || state_nxt != state_r) begin
                ext_hold_r <= 1'b0;
            end
            if (din_rise && din_fn_r == `DIN_RESTART_CYCLE_FUNCTION) begin
                saved_seg_r <= seg_r;
                seg_r       <= `SEG_FIRST;
                hrs_r       <= seg_time_r[13:6];
                min_r       <= seg_time_r[5:0];
            end else if (din_fall && din_fn_r == `DIN_RESTART_CYCLE_FUNCTION) begin
                seg_r <= saved_seg_r;
            end else if (din_rise && din_fn_r == `DIN_BEGIN) begin
                seg_r <= `SEG_FIRST;
                hrs_r <= seg_time_r[13:6];
                min_r <= seg_time_r[5:0];
            end else if (wr_i && addr_i == `REG_TIME &&
                         state_r != ST_RUN) begin
                hrs_r <= wdata_i[13:6];
                min_r <= (wdata_i[5:0] > 6'h3B) ? 6'h3B : wdata_i[5:0];
            end else if (wr_i && addr_i == `REG_CYCLES &&
                         state_r != ST_RUN) begin
                cycles_r <= (wdata_i[6:0] > `CYC_MAX) ?
                            `CYC_MAX : wdata_i[6:0];
            end else if (state_r == ST_RUN) begin
                if (is_soak && !soak_armed_r && pv_at_sp_i) begin
                    soak_armed_r <= 1'b1;
                end
                if (!is_soak || (soak_armed_r &&
                    (!soak_band_nz_r || pv_in_band_i))) begin
                    if (minute_tick) begin
                        tick_cnt_r <= 40'h0000000000;
                    end else begin
                        tick_cnt_r <= tick_cnt_r + 40'h0000000001;
                    end
                    if (minute_tick) begin
                        if (seg_done) begin
                            soak_armed_r <= 1'b0;
                            hrs_r <= seg_time_r[13:6];
                            min_r <= seg_time_r[5:0];
                            if (seg_r != `SEG_LAST) begin
                                seg_r <= seg_r + 4'h1;
                            end else if (cycles_r != 7'h00) begin
                                seg_r    <= `SEG_FIRST;
                                cycles_r <= cycles_r - 7'h01;
                            end
                        end else if (min_r == 6'h00) begin
                            min_r <= 6'h3B;
                            hrs_r <= hrs_r - 8'h01;
                        end else begin
                            min_r <= min_r - 6'h01;
                        end
                    end
                end
            end
        end
    end

    // Configuration registers, writable only while not running (hold or end)
    always @(posedge core_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ctrl_r         <= 6'h00;
            din_fn_r       <= `DIN_NONE;
            seg_soak_r     <= `SEG_MASK_RST;
            seg_time_r     <= 14'h0000;
            soak_band_nz_r <= 1'b0;
            cycles_cfg_r   <= `CYCLES_RST;
        end else if (wr_i && state_r != ST_RUN) begin
            case (addr_i)
                `REG_CTRL:    ctrl_r <= {wdata_i[5:2], 2'b00};
                `REG_DIN_CFG: din_fn_r <= wdata_i[2:0];
                `REG_SEG_CFG: begin
                    seg_soak_r <= wdata_i[11:0];
                end
                `REG_SOAK:    soak_band_nz_r <= (wdata_i != 16'h0000);
                `REG_TIME:    seg_time_r <= wdata_i[13:0];
                `REG_CYCLES:  cycles_cfg_r <= wdata_i[6:0];
                default:      ctrl_r <= ctrl_r;
            endcase
        end
    end

    // Outputs and indicators
    always @(posedge core_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            blink_r           <= 27'h0000000;
            running_o         <= 1'b0;
            hold_ind_o        <= 1'b0;
            sp_frozen_o       <= 1'b0;
            sp_restore_o      <= 1'b0;
            manual_failsafe_o <= 1'b0;
            manual_mode_o     <= 1'b0;
            param_refused_o   <= 1'b0;
            rdata_o           <= 16'h0000;
        end else begin
            blink_r     <= blink_r + 27'h0000001;
            running_o   <= (state_nxt == ST_RUN);
            sp_frozen_o <= (state_nxt != ST_RUN);
            if (ext_hold_r) begin
                hold_ind_o <= blink_r[`BLINK_BIT];
            end else begin
                hold_ind_o <= (state_nxt == ST_HOLD);
            end
            if (power_up_mode_setting_r) begin
                sp_restore_o  <= 1'b1;
                manual_mode_o <= !ctrl_r[`CTRL_PWR_AUTO];
            end else if (state_nxt == ST_RUN) begin
                sp_restore_o <= 1'b0;
            end
            if (state_nxt == ST_OFF && state_r != ST_OFF) begin
                manual_failsafe_o <= !ctrl_r[`CTRL_END_LAST];
                manual_mode_o     <= !ctrl_r[`CTRL_END_LAST];
            end else if (state_nxt == ST_RUN) begin
                manual_failsafe_o <= 1'b0;
            end
            param_refused_o <= param_wr && state_r == ST_RUN;
            if (rd_i) begin
                case (addr_i)
                    `REG_CTRL:    rdata_o <= {10'h000, ctrl_r};
                    `REG_STATUS:  rdata_o <= {11'h000, ext_hold_r,
                                  din_stable_r, state_r};
                    `REG_SEGMENT: rdata_o <= {11'h000, is_soak, seg_r};
                    `REG_TIME:    rdata_o <= {2'b00, hrs_r, min_r};
                    `REG_CYCLES:  rdata_o <= {9'h000, cycles_r};
                    `REG_SEG_CFG: rdata_o <= {4'h0, seg_soak_r};
                    `REG_DIN_CFG: rdata_o <= {13'h0000, din_fn_r};
                    `REG_SOAK:    rdata_o <= {15'h0000, soak_band_nz_r};
                    default:      rdata_o <= 16'h0000;
                endcase
            end else begin
                rdata_o <= 16'h0000;
            end
        end
    end

endmodule // spp_sequencer

`default_nettype wire

/* File: shared/spp_map.vh */
// Constants for the setpoint program run/hold sequencer
`ifndef SPP_MAP_VH
`define SPP_MAP_VH

// Register indices
`define REG_CTRL        4'h0
`define REG_STATUS      4'h1
`define REG_SEGMENT     4'h2
`define REG_TIME        4'h3
`define REG_CYCLES      4'h4
`define REG_SEG_CFG     4'h5
`define REG_DIN_CFG     4'h6
`define REG_SOAK        4'h7
`define REG_PROC        4'h8

// Control register fields
`define CTRL_RUN_KEY    0
`define CTRL_HOLD_KEY   1
`define CTRL_END_HOLD   2
`define CTRL_END_LAST   3
`define CTRL_PWR_AUTO   4
`define CTRL_HOLD_SOAK  5

// Digital input functions
`define DIN_NONE        3'h0
`define DIN_RUN_HOLD    3'h1
`define DIN_RESTART_CYCLE_FUNCTION       3'h2
`define DIN_BEGIN       3'h3
`define DIN_FN_RUN      3'h4

// Limits and reset values
`define SEG_FIRST       4'h1
`define SEG_LAST        4'hC
`define CYC_MAX         7'h63
`define CYCLES_RST      7'h00
`define SEG_MASK_RST    12'hAAA

// Timing: one minute tick at 200 MHz
`define MINUTE_NS       64'd60000000000
`define CLK_NS          64'd5
`define MINUTE_CYC      40'd12000000000
`define DEB_NS          20'd1000000
`define DEB_CYC         20'd200000
`define BLINK_BIT       26

`endif

/* File: verif/spp_contact_model.sv */
// Dry-contact switch model driving the sequencer's digital input
`default_nettype none

module spp_contact_model (
    input  wire logic clk_i,
    input  wire logic close_i,
    output var  logic contact_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial contact_o = 1'b0;
    // Contact moves just after an edge, then holds its level
    always @(posedge clk_i) begin
        contact_o <= close_i;
    end
endmodule // spp_contact_model

`default_nettype wire

/* File: verif/spp_checker_props.sv */
// Port-level assertions for the run/hold sequencer
`include "spp_map.vh"
`default_nettype none

module spp_checker #(
    parameter [39:0] MINUTE_CYCLES = 40'd10,
    parameter [19:0] DEB_CYCLES    = 20'd4
) (
    input wire logic        core_clk_i,
    input wire logic        resetn_i,
    input wire logic [3:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic        running_o,
    input wire logic        sp_frozen_o,
    input wire logic        sp_restore_o,
    input wire logic        manual_failsafe_o,
    input wire logic        param_refused_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_run_press;
        wr_i && addr_i == `REG_CTRL && wdata_i[1:0] == 2'b01;
    endsequence
    sequence s_hold_press;
        wr_i && addr_i == `REG_CTRL && wdata_i[1:0] == 2'b10;
    endsequence
    a_run_key_start: assert property (s_run_press |=> running_o)
        else $error("run key did not start program");
    a_hold_key_stop: assert property
        (s_hold_press |=> !running_o && sp_frozen_o)
        else $error("hold key did not hold program");
    a_frozen_excl: assert property (running_o |-> !sp_frozen_o)
        else $error("setpoint frozen while running");
    a_refuse_cause: assert property
        (wr_i && running_o && addr_i == `REG_CYCLES |=> param_refused_o)
        else $error("write while running not refused");
    a_refuse_source: assert property
        (param_refused_o |-> $past(wr_i) && $past(running_o))
        else $error("refusal without running write");
    a_seg_range: assert property
        (rd_i && addr_i == `REG_SEGMENT |=> rdata_o[3:0] >= `SEG_FIRST
         && rdata_o[3:0] <= `SEG_LAST && rdata_o[15:5] == 11'h000)
        else $error("segment number out of range");
    a_cycles_range: assert property
        (rd_i && addr_i == `REG_CYCLES |=> rdata_o <= 16'h0063)
        else $error("cycles left above limit");
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside read slot");
    a_unmapped_zero: assert property
        (rd_i && addr_i > `REG_PROC |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_restore_clear: assert property
        (running_o ##1 running_o |-> !sp_restore_o)
        else $error("restore kept while running");
    a_end_no_run: assert property (manual_failsafe_o |-> !running_o)
        else $error("failsafe while running");
endmodule // spp_checker

bind spp_sequencer spp_checker #(.MINUTE_CYCLES(MINUTE_CYCLES),
    .DEB_CYCLES(DEB_CYCLES)) u_chk (.core_clk_i, .resetn_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .running_o, .sp_frozen_o,
    .sp_restore_o, .manual_failsafe_o, .param_refused_o);

`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking testbench for the run/hold sequencer
`include "spp_map.vh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata, rd_val;
    logic        wr = 1'b0, rd = 1'b0, close_req = 1'b0, contact;
    logic        running, hold_ind, frozen, restore, failsafe, manual;
    logic        refused;
    int          fail_count = 0, samples_checked = 0;
    always #2.5 clk = ~clk;
    spp_contact_model u_sw (.clk_i(clk), .close_i(close_req),
        .contact_o(contact));
    spp_sequencer #(.MINUTE_CYCLES(40'd10), .DEB_CYCLES(20'd4)) DUT (
        .core_clk_i(clk), .resetn_i(rst_n), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .din_contact_i(contact), .pv_at_sp_i(1'b1), .pv_in_band_i(1'b1),
        .running_o(running), .hold_ind_o(hold_ind), .sp_frozen_o(frozen),
        .sp_restore_o(restore), .manual_failsafe_o(failsafe),
        .manual_mode_o(manual), .param_refused_o(refused));
    task close_out;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk1(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 rd_val = rdata;
    endtask
    task do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        tick(20);
        rst_n <= 1'b1;
        tick(4);
    endtask
    task switch_to(input logic v);
        @(posedge clk);
        close_req <= v;
        tick(12);
    endtask
    task wait_seg(input logic [15:0] s);
        rd_val = 16'hFFFF;
        for (int i = 0; i < 100 && rd_val !== s; i++) rd_reg(`REG_SEGMENT);
        chk(rd_val, s);
    endtask
    task t_power_up;
        chk1(running, 1'b0);
        chk1(restore, 1'b1);
        chk1(manual, 1'b1);
        rd_reg(`REG_SEGMENT);
        chk(rd_val, 16'h0001);
        rd_reg(`REG_CYCLES);
        chk(rd_val, 16'h0000);
        rd_reg(4'hF);
        chk(rd_val, 16'h0000);
        $display("done power_up");
    endtask
    task t_params;
        wr_reg(`REG_TIME, 16'h0002);
        rd_reg(`REG_TIME);
        chk(rd_val, 16'h0002);
        wr_reg(`REG_CTRL, 16'h0001);
        tick(1);
        chk1(running, 1'b1);
        chk1(hold_ind, 1'b0);
        wr_reg(`REG_CYCLES, 16'h0005);
        tick(0);
        chk1(refused, 1'b1);
        rd_reg(`REG_CYCLES);
        chk(rd_val, 16'h0000);
        $display("done params");
    endtask
    task t_hold;
        logic [15:0] s1;
        wr_reg(`REG_CTRL, 16'h0002);
        tick(1);
        chk1(running, 1'b0);
        chk1(hold_ind, 1'b1);
        chk1(frozen, 1'b1);
        rd_reg(`REG_SEGMENT);
        s1 = rd_val;
        tick(50);
        rd_reg(`REG_SEGMENT);
        chk(rd_val, s1);
        $display("done hold");
    endtask
    task t_end;
        wr_reg(`REG_CTRL, 16'h0001);
        wait_seg(16'h0012);
        for (int i = 0; i < 1000 && running === 1'b1; i++) tick(1);
        chk1(running, 1'b0);
        chk1(failsafe, 1'b1);
        chk1(manual, 1'b1);
        $display("done end");
    endtask
    task t_contact;
        wr_reg(`REG_TIME, 16'h0002);
        wr_reg(`REG_DIN_CFG, {13'h0000, `DIN_RUN_HOLD});
        wr_reg(`REG_CTRL, 16'h0001);
        switch_to(1'b1);
        chk1(running, 1'b0);
        switch_to(1'b0);
        chk1(running, 1'b1);
        wr_reg(`REG_CTRL, 16'h0002);
        wr_reg(`REG_DIN_CFG, {13'h0000, `DIN_RESTART_CYCLE_FUNCTION});
        wr_reg(`REG_CTRL, 16'h0001);
        wait_seg(16'h0012);
        switch_to(1'b1);
        chk1(running, 1'b1);
        rd_reg(`REG_SEGMENT);
        chk(rd_val, 16'h0001);
        switch_to(1'b0);
        $display("done contact");
    endtask
    task t_begin;
        wr_reg(`REG_CTRL, 16'h0002);
        wr_reg(`REG_DIN_CFG, {13'h0000, `DIN_BEGIN});
        wr_reg(`REG_CYCLES, 16'h0005);
        wr_reg(`REG_CTRL, 16'h0001);
        wait_seg(16'h0012);
        switch_to(1'b1);
        chk1(running, 1'b0);
        rd_reg(`REG_SEGMENT);
        chk(rd_val, 16'h0001);
        rd_reg(`REG_CYCLES);
        chk(rd_val, 16'h0005);
        switch_to(1'b0);
        chk1(running, 1'b0);
        wr_reg(`REG_DIN_CFG, {13'h0000, `DIN_FN_RUN});
        switch_to(1'b1);
        chk1(running, 1'b1);
        switch_to(1'b0);
        chk1(running, 1'b0);
        $display("done begin");
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        close_out;
    end
    initial begin
        do_reset;
        t_power_up;
        t_params;
        t_hold;
        t_end;
        do_reset;
        t_contact;
        t_begin;
        close_out;
    end
endmodule // tb_top

`default_nettype wire
